// ### core/icm_pkg.sv
/*
  Constants, types and helpers shared by the infrared carrier modulator.
  Assumes a single 40 MHz clock and an AXI4-Lite master with 32-bit data.
*/
// Behaviour
// - fsk select 0 time/baseband, 1 frequency shift
// - interrupt when cycle flag set and enabled
// - enable initialises generator and modulator, runs
// - disable finishes cycle, stops, output forced low
// - mark/space buffers copied at start and at period end
// - one carrier count per prescaled clock
// - carrier period two to 510 counts
// - carrier period is high plus low counts
// - modulator tick is carrier clock over eight
// - baseband holds carrier at active level
// - fsk swaps count sets at each period end
// - modulator counts clocks or carrier periods
// - modulator output drives pin while running
// - time mode uses primary counts, gated
// - status read then low-byte access clears flag
// - prescaler divides by 1, 2, 4, 8
// - 8-bit up counter restarts at one, toggles
// - 17-bit down counter, sign closes gate
`default_nettype none
package icm_pkg;
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MARK_HIGH      = 8'h04;
  localparam logic [7:0] ADDR_MARK_LOW       = 8'h08;
  localparam logic [7:0] ADDR_SPACE_HIGH     = 8'h0c;
  localparam logic [7:0] ADDR_SPACE_LOW      = 8'h10;
  localparam logic [7:0] ADDR_CARRIER_PRI    = 8'h14;
  localparam logic [7:0] ADDR_CARRIER_SEC    = 8'h18;
  localparam logic [7:0] ADDR_OUTPUT_CTRL    = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h20;
  localparam logic [7:0] ADDR_IRQ_CLEAR      = 8'h24;
  localparam logic [7:0] ADDR_IRQ_ENABLE     = 8'h28;
  // status/control bit positions
  localparam int BIT_FLAG      = 7;
  localparam int BIT_DIV       = 5;
  localparam int BIT_EXT_SPACE = 4;
  localparam int BIT_BASE      = 3;
  localparam int BIT_FSK       = 2;
  localparam int BIT_IRQ_EN    = 1;
  localparam int BIT_ENABLE    = 0;
  // output control bit positions
  localparam int BIT_POLARITY  = 2;
  localparam int BIT_PIN_EN    = 1;
  localparam int BIT_LATCH     = 0;
  // irq status bits
  localparam int IRQ_CYCLE_END = 0;
  localparam int IRQ_STOPPED   = 1;
  localparam int IRQ_W         = 2;
  localparam logic [7:0]  RST_COUNT     = 8'h01;
  localparam logic [15:0] RST_PERIOD    = 16'h0000;
  localparam logic [7:0]  CARRIER_START = 8'h01;
  localparam logic [2:0]  MOD_DIV_LAST  = 3'h7;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOPPING} icm_gen_state_t;
  // last prescaler count for divide-by 1, 2, 4, 8
  function automatic logic [2:0] prescaleLast(input logic [1:0] sel);
    case (sel)
      2'h0:    prescaleLast = 3'h0;
      2'h1:    prescaleLast = 3'h1;
      2'h2:    prescaleLast = 3'h3;
      default: prescaleLast = 3'h7;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### core/icm_carrier_if.sv
/*
  Link between the modulator control and the carrier generator.
  Assumes both ends share mclk.
*/
`default_nettype none
interface icm_carrier_if;
  logic       tick;
  logic       init;
  logic       run;
  logic       base;
  logic       useSecondary;
  logic [7:0] priHigh;
  logic [7:0] priLow;
  logic [7:0] secHigh;
  logic [7:0] secLow;
  logic       carrierOut;
  logic       periodEnd;
  modport gen (input tick, init, run, base, useSecondary, priHigh, priLow, secHigh, secLow,
               output carrierOut, periodEnd);
  modport ctl (output tick, init, run, base, useSecondary, priHigh, priLow, secHigh, secLow,
               input carrierOut, periodEnd);
endinterface
`default_nettype wire

// ### core/icm_carrier_gen.sv
/*
  Carrier generator: 8-bit up counter toggling between high and low counts.
  Assumes non-zero counts and a one-cycle tick from the prescaler.
*/
`default_nettype none
module icm_carrier_gen (
  input wire logic  mclk,
  input wire logic  reset_n,
  icm_carrier_if.gen cg
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       level;
  } icm_cg_state_t;

  icm_cg_state_t q;
  icm_cg_state_t d;
  logic [7:0]    cmpVal;
  logic          match;

  always_comb begin
    d      = q;
    cmpVal = q.level ? (cg.useSecondary ? cg.secHigh : cg.priHigh)
                     : (cg.useSecondary ? cg.secLow : cg.priLow);
    match  = (q.cnt == cmpVal);
    if (cg.init) begin
      d.cnt   = icm_pkg::CARRIER_START;
      d.level = 1'b1;
    end else if (cg.run && !cg.base && cg.tick) begin
      if (match) begin
        d.cnt   = icm_pkg::CARRIER_START;
        d.level = !q.level;
      end else begin
        d.cnt = q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      q <= '{cnt: icm_pkg::CARRIER_START, level: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign cg.carrierOut = cg.base ? 1'b1 : q.level;
  assign cg.periodEnd  = cg.run && cg.tick && (cg.base || (!q.level && match));

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_carrier_restart: assert property (cg.run && cg.tick && !cg.base && !cg.init && match |=> q.cnt == 8'h01)
    else $error("carrier counter did not restart at one");
  a_base_level: assert property (cg.base |-> cg.carrierOut)
    else $error("baseband carrier not at active level");
endmodule
`default_nettype wire

// ### core/icm_modulator.sv
/*
  Infrared carrier modulator top: AXI4-Lite registers, prescaler, modulator,
  cycle-end flag, interrupts and pin output. Assumes one clock, mclk,
  synchronous active-low reset and an external pad honouring infraredOutEn.
*/
`default_nettype none
module icm_modulator #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   infraredOutPin,
  output logic                   infraredOutEn,
  output logic                   irq
);
  typedef struct packed {
    icm_pkg::icm_gen_state_t state;
    logic                    enable;
    logic                    irqEn;
    logic                    freq_shift_select;
    logic                    base;
    logic                    extSpace;
    logic [1:0]              div;
    logic                    flag;
    logic                    clearArmed;
    logic [15:0]             markBuf;
    logic [15:0]             spaceBuf;
    logic [7:0]              priHigh;
    logic [7:0]              priLow;
    logic [7:0]              secHigh;
    logic [7:0]              secLow;
    logic                    polarity;
    logic                    pinEn;
    logic                    latch;
    logic [icm_pkg::IRQ_W-1:0] irqStatus;
    logic [icm_pkg::IRQ_W-1:0] irqEnable;
    logic [2:0]              psCnt;
    logic [2:0]              modDiv;
    logic [16:0]             modCnt;
    logic [15:0]             spaceReg;
    logic                    useSec;
    logic                    extActive;
    logic                    pinLevel;
    logic                    awHave;
    logic [ADDR_W-1:0]       awAddr;
    logic                    wHave;
    logic [31:0]             wData;
    logic [3:0]              wStrb;
    logic                    bValid;
    logic [1:0]              bResp;
    logic                    rValid;
    logic [31:0]             rData;
    logic [1:0]              rResp;
  } icm_state_t;

  icm_state_t    q;
  icm_state_t    d;
  icm_carrier_if cg ();

  logic        running;
  logic        start;
  logic        psTick;
  logic        modTick;
  logic [16:0] modNext;
  logic        cycleEnd;
  logic        gate;
  logic        modOut;
  logic        wrDo;
  logic        rdDo;
  logic        lowAccess;
  logic [7:0]  rdAddr;
  logic [7:0]  wrAddr;
  logic [31:0] rdVal;
  logic        rdOk;
  logic        wrOk;
  logic [7:0]  statusByte;

  icm_carrier_gen u_carrier (
    .mclk    (mclk),
    .reset_n (reset_n),
    .cg      (cg.gen)
  );

  assign running = (q.state != icm_pkg::ST_IDLE);
  assign start   = !running && q.enable;
  assign gate    = running && !q.modCnt[16] && !q.extActive;
  assign modOut  = gate && cg.carrierOut;
  assign statusByte = {q.flag, q.div, q.extSpace, q.base, q.freq_shift_select, q.irqEn, q.enable};

  assign cg.tick         = psTick;
  assign cg.init         = start;
  assign cg.run          = running;
  assign cg.base         = q.base;
  assign cg.useSecondary = q.useSec;
  assign cg.priHigh      = q.priHigh;
  assign cg.priLow       = q.priLow;
  assign cg.secHigh      = q.secHigh;
  assign cg.secLow       = q.secLow;

  assign rdAddr = 8'(s_axi_araddr);
  assign wrAddr = 8'(q.awAddr);
  assign rdDo   = s_axi_arvalid && s_axi_arready;
  assign wrDo   = q.awHave && q.wHave && !q.bValid;

  // prescaler and modulator tick
  always_comb begin
    psTick  = running && (q.psCnt == icm_pkg::prescaleLast(q.div));
    modTick = q.freq_shift_select ? cg.periodEnd : (psTick && q.modDiv == icm_pkg::MOD_DIV_LAST);
    modNext = q.modCnt - 17'h00001;
    cycleEnd = running && modTick && modNext[16] && (~modNext[15:0] == q.spaceReg);
  end

  // register read decode
  always_comb begin
    rdVal = 32'h0000_0000;
    rdOk  = 1'b1;
    case (rdAddr)
      icm_pkg::ADDR_STATUS_CONTROL: rdVal = {24'h00_0000, statusByte};
      icm_pkg::ADDR_MARK_HIGH:      rdVal = {24'h00_0000, q.markBuf[15:8]};
      icm_pkg::ADDR_MARK_LOW:       rdVal = {24'h00_0000, q.markBuf[7:0]};
      icm_pkg::ADDR_SPACE_HIGH:     rdVal = {24'h00_0000, q.spaceBuf[15:8]};
      icm_pkg::ADDR_SPACE_LOW:      rdVal = {24'h00_0000, q.spaceBuf[7:0]};
      icm_pkg::ADDR_CARRIER_PRI:    rdVal = {16'h0000, q.priLow, q.priHigh};
      icm_pkg::ADDR_CARRIER_SEC:    rdVal = {16'h0000, q.secLow, q.secHigh};
      icm_pkg::ADDR_OUTPUT_CTRL:    rdVal = {29'h0000_0000, q.polarity, q.pinEn, q.latch};
      icm_pkg::ADDR_IRQ_STATUS:     rdVal = {30'h0000_0000, q.irqStatus};
      icm_pkg::ADDR_IRQ_CLEAR:      rdVal = 32'h0000_0000;
      icm_pkg::ADDR_IRQ_ENABLE:     rdVal = {30'h0000_0000, q.irqEnable};
      default:                      rdOk  = 1'b0;
    endcase
  end

  always_comb begin
    wrOk = 1'b1;
    case (wrAddr)
      icm_pkg::ADDR_STATUS_CONTROL, icm_pkg::ADDR_MARK_HIGH, icm_pkg::ADDR_MARK_LOW,
      icm_pkg::ADDR_SPACE_HIGH, icm_pkg::ADDR_SPACE_LOW, icm_pkg::ADDR_CARRIER_PRI,
      icm_pkg::ADDR_CARRIER_SEC, icm_pkg::ADDR_OUTPUT_CTRL, icm_pkg::ADDR_IRQ_STATUS,
      icm_pkg::ADDR_IRQ_CLEAR, icm_pkg::ADDR_IRQ_ENABLE: wrOk = 1'b1;
      default: wrOk = 1'b0;
    endcase
  end

  assign lowAccess = (rdDo && (rdAddr == icm_pkg::ADDR_MARK_LOW || rdAddr == icm_pkg::ADDR_SPACE_LOW))
                  || (wrDo && (wrAddr == icm_pkg::ADDR_MARK_LOW || wrAddr == icm_pkg::ADDR_SPACE_LOW));

  always_comb begin
    d = q;
    // bus channels
    if (s_axi_awvalid && s_axi_awready) begin
      d.awHave = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.wHave = 1'b1;
      d.wData = s_axi_wdata;
      d.wStrb = s_axi_wstrb;
    end
    if (q.bValid && s_axi_bready) begin
      d.bValid = 1'b0;
    end
    if (q.rValid && s_axi_rready) begin
      d.rValid = 1'b0;
    end
    if (rdDo) begin
      d.rValid = 1'b1;
      d.rData  = rdVal;
      d.rResp  = rdOk ? icm_pkg::RESP_OKAY : icm_pkg::RESP_SLVERR;
    end
    // flag clear sequence, then sets below win
    if (lowAccess && q.clearArmed) begin
      d.flag       = 1'b0;
      d.clearArmed = 1'b0;
    end
    if (rdDo && rdAddr == icm_pkg::ADDR_STATUS_CONTROL && q.flag) begin
      d.clearArmed = 1'b1;
    end
    if (wrDo) begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bValid = 1'b1;
      d.bResp  = wrOk ? icm_pkg::RESP_OKAY : icm_pkg::RESP_SLVERR;
      if (q.wStrb[0]) begin
        case (wrAddr)
          icm_pkg::ADDR_STATUS_CONTROL: begin
            d.enable   = q.wData[icm_pkg::BIT_ENABLE];
            d.irqEn    = q.wData[icm_pkg::BIT_IRQ_EN];
            d.freq_shift_select      = q.wData[icm_pkg::BIT_FSK];
            d.base     = q.wData[icm_pkg::BIT_BASE];
            d.extSpace = q.wData[icm_pkg::BIT_EXT_SPACE];
            d.div      = q.wData[icm_pkg::BIT_DIV +: 2];
          end
          icm_pkg::ADDR_MARK_HIGH:   d.markBuf[15:8]  = q.wData[7:0];
          icm_pkg::ADDR_MARK_LOW:    d.markBuf[7:0]   = q.wData[7:0];
          icm_pkg::ADDR_SPACE_HIGH:  d.spaceBuf[15:8] = q.wData[7:0];
          icm_pkg::ADDR_SPACE_LOW:   d.spaceBuf[7:0]  = q.wData[7:0];
          icm_pkg::ADDR_CARRIER_PRI: d.priHigh = q.wData[7:0];
          icm_pkg::ADDR_CARRIER_SEC: d.secHigh = q.wData[7:0];
          icm_pkg::ADDR_OUTPUT_CTRL: begin
            d.polarity = q.wData[icm_pkg::BIT_POLARITY];
            d.pinEn    = q.wData[icm_pkg::BIT_PIN_EN];
            d.latch    = q.wData[icm_pkg::BIT_LATCH];
          end
          icm_pkg::ADDR_IRQ_CLEAR:   d.irqStatus = q.irqStatus & ~q.wData[icm_pkg::IRQ_W-1:0];
          icm_pkg::ADDR_IRQ_ENABLE:  d.irqEnable = q.wData[icm_pkg::IRQ_W-1:0];
          default: ;
        endcase
      end
      if (q.wStrb[1]) begin
        case (wrAddr)
          icm_pkg::ADDR_CARRIER_PRI: d.priLow = q.wData[15:8];
          icm_pkg::ADDR_CARRIER_SEC: d.secLow = q.wData[15:8];
          default: ;
        endcase
      end
    end
    // prescaler and modulator
    if (running) begin
      d.psCnt = psTick ? 3'h0 : q.psCnt + 3'h1;
      if (psTick) begin
        d.modDiv = q.modDiv + 3'h1;
      end
      if (cycleEnd) begin
        d.modCnt    = {1'b0, q.markBuf};
        d.spaceReg  = q.spaceBuf;
        d.extActive = q.extSpace;
        if (q.freq_shift_select) begin
          d.useSec = !q.useSec;
        end
      end else if (modTick) begin
        d.modCnt = modNext;
      end
    end
    // generator state
    case (q.state)
      icm_pkg::ST_IDLE: begin
        if (q.enable) begin
          d.state     = icm_pkg::ST_RUN;
          d.psCnt     = 3'h0;
          d.modDiv    = 3'h0;
          d.modCnt    = {1'b0, q.markBuf};
          d.spaceReg  = q.spaceBuf;
          d.useSec    = 1'b0;
          d.extActive = q.extSpace;
          d.flag      = 1'b1;
          d.irqStatus[icm_pkg::IRQ_CYCLE_END] = 1'b1;
        end
      end
      icm_pkg::ST_RUN, icm_pkg::ST_STOPPING: begin
        if (cycleEnd && !q.enable) begin
          d.state = icm_pkg::ST_IDLE;
          d.irqStatus[icm_pkg::IRQ_STOPPED] = 1'b1;
        end else begin
          d.state = q.enable ? icm_pkg::ST_RUN : icm_pkg::ST_STOPPING;
        end
      end
      default: d.state = icm_pkg::ST_IDLE;
    endcase
    if (cycleEnd) begin
      d.flag = 1'b1;
      d.irqStatus[icm_pkg::IRQ_CYCLE_END] = 1'b1;
    end
    // pin level: modulator when running, latch otherwise
    d.pinLevel = (running ? modOut : q.latch) ~^ q.polarity;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      q           <= '0;
      q.state     <= icm_pkg::ST_IDLE;
      q.markBuf   <= icm_pkg::RST_PERIOD;
      q.spaceBuf  <= icm_pkg::RST_PERIOD;
      q.priHigh   <= icm_pkg::RST_COUNT;
      q.priLow    <= icm_pkg::RST_COUNT;
      q.secHigh   <= icm_pkg::RST_COUNT;
      q.secLow    <= icm_pkg::RST_COUNT;
      q.polarity  <= 1'b1;
      q.pinLevel  <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready  = !q.awHave && !q.bValid;
  assign s_axi_wready   = !q.wHave && !q.bValid;
  assign s_axi_bvalid   = q.bValid;
  assign s_axi_bresp    = q.bResp;
  assign s_axi_arready  = !q.rValid;
  assign s_axi_rvalid   = q.rValid;
  assign s_axi_rdata    = q.rData;
  assign s_axi_rresp    = q.rResp;
  assign infraredOutPin = q.pinLevel;
  assign infraredOutEn  = q.pinEn;
  assign irq = (q.flag && q.irqEn) || (|(q.irqStatus & q.irqEnable));

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_irq_flag_on: assert property (q.flag && q.irqEn |-> irq)
    else $error("irq missing with flag and enable set");
  a_irq_masked_off: assert property (!q.irqEn && !(|(q.irqStatus & q.irqEnable)) |-> !irq)
    else $error("irq raised while masked");
  a_start_loads: assert property (start |=> q.flag && q.modCnt == {1'b0, $past(q.markBuf)})
    else $error("start did not load mark and set flag");
  a_stop_waits: assert property (q.state == icm_pkg::ST_STOPPING && !cycleEnd && !q.enable
                                 |=> q.state == icm_pkg::ST_STOPPING)
    else $error("stopped before cycle end");
  a_idle_low: assert property (!running |-> !modOut)
    else $error("modulator output high while stopped");
  a_idle_pin: assert property (!$past(running) |-> infraredOutPin == ($past(q.latch) ~^ $past(q.polarity)))
    else $error("pin not at latch level while stopped");
  a_space_reload: assert property (cycleEnd |=> q.spaceReg == $past(q.spaceBuf))
    else $error("space period not reloaded");
  a_space_held: assert property (running && !cycleEnd |=> $stable(q.spaceReg))
    else $error("space period changed mid cycle");
  a_fsk_swap: assert property (cycleEnd && q.freq_shift_select |=> q.useSec != $past(q.useSec))
    else $error("count set not swapped in fsk");
  a_time_primary: assert property (!q.freq_shift_select && q.useSec == 1'b0 && running |=> !q.useSec)
    else $error("secondary counts used outside fsk");
  a_div8_gap: assert property (psTick && q.div == 2'h3 && q.state == icm_pkg::ST_RUN |=> (!psTick)[*7])
    else $error("prescale by eight ticked early");
  a_sign_closes: assert property (q.modCnt[16] |-> !gate)
    else $error("gate open with negative count");
  a_pin_follows: assert property (running && q.polarity |=> infraredOutPin == $past(modOut))
    else $error("pin does not follow modulator");
  a_flag_clear: assert property (q.clearArmed && lowAccess && !cycleEnd && !start |=> !q.flag)
    else $error("flag not cleared by access sequence");
  c_start: cover property (start);
  c_fsk_cycle: cover property (cycleEnd && q.freq_shift_select);
  c_stop_done: cover property (q.state == icm_pkg::ST_STOPPING ##1 q.state == icm_pkg::ST_IDLE);
  c_flag_clear: cover property (q.flag ##1 !q.flag);
endmodule
`default_nettype wire

// ### verification/icm_led_model.sv
/*
  Infrared LED model on the output pin: measures high and low run lengths.
  Assumes it shares mclk with the modulator and sees the pin and its enable.
*/
`default_nettype none
module icm_led_model (
  input  wire logic  mclk,
  input  wire logic  statClear,
  input  wire logic  pinLevel,
  input  wire logic  pinEn,
  output logic [15:0] maxHigh,
  output logic [15:0] maxLow
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        lastDriven;
  logic        prevLine;
  logic        lineLevel;
  logic [15:0] runLen;
  // released pin floats: shows inverse of last driven level
  assign lineLevel = pinEn ? pinLevel : ~lastDriven;
  always_ff @(posedge mclk) begin
    prevLine <= lineLevel;
    if (pinEn) begin
      lastDriven <= pinLevel;
    end
    if (statClear) begin
      runLen <= 16'h0000;
      maxHigh <= 16'h0000;
      maxLow <= 16'h0000;
    end else if (lineLevel != prevLine) begin
      runLen <= 16'h0001;
      // only complete runs count
      if (runLen != 16'h0000 && prevLine && runLen > maxHigh) begin
        maxHigh <= runLen;
      end
      if (runLen != 16'h0000 && !prevLine && runLen > maxLow) begin
        maxLow <= runLen;
      end
    end else if (runLen != 16'h0000) begin
      runLen <= runLen + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_icm_modulator.sv
/*
  Self-checking bench for the infrared carrier modulator over AXI4-Lite.
  Assumes the icm_pkg map and the LED model on the output pin.
*/
`default_nettype none
module tb_icm_modulator;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk;
  logic        reset_n;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  rr;
  logic [1:0]  br;
  logic        awvalid;
  logic        awready;
  logic        wvalid;
  logic        wready;
  logic        bvalid;
  logic        bready;
  logic        arvalid;
  logic        arready;
  logic        rvalid;
  logic        rready;
  logic        pin;
  logic        pinEn;
  logic        irq;
  logic        statClear;
  logic [15:0] maxHigh;
  logic [15:0] maxLow;
  int          failures;
  int          comparisons;

  icm_modulator i_dut (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .infraredOutPin(pin),
    .infraredOutEn(pinEn), .irq(irq));
  icm_led_model i_led (.mclk(mclk), .statClear(statClear), .pinLevel(pin), .pinEn(pinEn),
    .maxHigh(maxHigh), .maxLow(maxLow));

  task automatic finish_test();
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) begin
        awvalid <= 1'b0;
      end
      if (wready) begin
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    br = bresp;
    bready <= 1'b0;
  endtask

  task automatic axRead(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) begin
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  task automatic measure(input int n);
    statClear <= 1'b1;
    @(posedge mclk);
    statClear <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  task automatic runMode(input logic [7:0] cfg, input logic [15:0] expHigh, input logic [15:0] expLow);
    axWrite(icm_pkg::ADDR_STATUS_CONTROL, {24'h0, cfg});
    measure(1200);
    chk({16'h0, maxHigh}, {16'h0, expHigh});
    if (expLow != 16'h0000) begin
      chk({16'h0, maxLow}, {16'h0, expLow});
    end
    axWrite(icm_pkg::ADDR_STATUS_CONTROL, 32'h0);
    repeat (400) @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    finish_test();
  end

  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, statClear} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    failures = 0;
    comparisons = 0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    axRead(icm_pkg::ADDR_STATUS_CONTROL);
    chk(rd, 32'h0);
    axRead(icm_pkg::ADDR_OUTPUT_CTRL);
    chk(rd, 32'h4);
    axRead(8'h30);
    chk({30'h0, rr}, {30'h0, icm_pkg::RESP_SLVERR});
    chk(rd, 32'h0);
    axWrite(8'h30, 32'h0);
    chk({30'h0, br}, {30'h0, icm_pkg::RESP_SLVERR});
    // all data registers before enabling
    axWrite(icm_pkg::ADDR_MARK_HIGH, 32'h0);
    axWrite(icm_pkg::ADDR_MARK_LOW, 32'h3);
    axWrite(icm_pkg::ADDR_SPACE_HIGH, 32'h0);
    axWrite(icm_pkg::ADDR_SPACE_LOW, 32'h2);
    axWrite(icm_pkg::ADDR_CARRIER_PRI, 32'h0302);
    axWrite(icm_pkg::ADDR_CARRIER_SEC, 32'h0105);
    axWrite(icm_pkg::ADDR_OUTPUT_CTRL, 32'h6);
    axWrite(icm_pkg::ADDR_IRQ_ENABLE, 32'h2);
    chk({31'h0, pinEn}, 32'h1);
    axWrite(icm_pkg::ADDR_STATUS_CONTROL, 32'h3);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    axRead(icm_pkg::ADDR_STATUS_CONTROL);
    chk(rd & 32'h80, 32'h80);
    axRead(icm_pkg::ADDR_MARK_LOW);
    axRead(icm_pkg::ADDR_STATUS_CONTROL);
    chk(rd & 32'h80, 32'h0);
    chk({31'h0, irq}, 32'h0);
    measure(300);
    chk({16'h0, maxHigh}, 32'h2);
    chk({31'h0, irq}, 32'h1);
    axWrite(icm_pkg::ADDR_STATUS_CONTROL, 32'h0);
    repeat (100) @(posedge mclk);
    chk({31'h0, pin}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    axRead(icm_pkg::ADDR_IRQ_STATUS);
    chk(rd, 32'h3);
    axWrite(icm_pkg::ADDR_IRQ_CLEAR, 32'h2);
    chk({31'h0, irq}, 32'h0);
    measure(200);
    chk({16'h0, maxHigh}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      runMode(8'h09 | 8'(k * 32), 16'(32 << k), 16'(16 << k));
    end
    runMode(8'h21, 16'h0004, 16'h0000);
    runMode(8'h05, 16'h0005, 16'h0000);
    runMode(8'h19, 16'h0000, 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
